// [src/sclab_device.sv]
`timescale 1ns/10ps
module sclab_device import sclab_pkg::*; #(
   parameter int SPLASH_CYCLES = SPLASH_CYC
) (
   input wire logic clk,
   input wire logic reset_n,
   sclab_link_if.dev link,
   output logic [7:0] cmd_data,
   output logic cmd_valid,
   input wire logic [7:0] rsp_data,
   input wire logic rsp_valid,
   output logic rsp_ready,
   input wire logic done_req,
   input wire logic done_ok,
   output logic done_ready,
   output logic baud_locked,
   output logic link_ready,
   output logic splash_on,
   output logic [BIT_W-1:0] bit_cycles
);
   logic rxd_s1_ff;
   logic rxd_s2_ff;
   logic rxd_d_ff;
   logic rst_s1_ff;
   logic rst_s2_ff;
   logic [RSTC_W-1:0] rstc_ff;
   logic pin_rst_ff;
   logic srst_n;
   sclab_rx_e st_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic [BIT_W-1:0] bit_per_ff;
   logic [2:0] nb_ff;
   logic [7:0] rsh_ff;
   logic [7:0] cmd_data_ff;
   logic cmd_valid_ff;
   logic locked_ff;
   logic ab_pend_ff;
   logic ready_ff;
   logic [SPW-1:0] spl_ff;
   logic splash_ff;
   logic txd_ff;
   logic tbusy_ff;
   logic [8:0] tsh_ff;
   logic [3:0] tbit_ff;
   logic [BIT_W-1:0] tcnt_ff;
   logic fall;
   logic lock_evt;
   logic bit_end;
   logic [CNT_W-1:0] bit_last;
   logic [7:0] fin_data;
   logic fin_valid;
   logic fin_ready;
   logic [7:0] fout_data;
   logic fout_valid;
   logic fout_ready;

   // Line and reset pin synchronisers
   // Line stages clear low, so no false fall follows reset
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rxd_s1_ff <= 1'b0;
         rxd_s2_ff <= 1'b0;
         rxd_d_ff <= 1'b0;
         rst_s1_ff <= 1'b1;
         rst_s2_ff <= 1'b1;
      end else begin
         rxd_s1_ff <= link.host_txd;
         rxd_s2_ff <= rxd_s1_ff;
         rxd_d_ff <= rxd_s2_ff;
         rst_s1_ff <= link.rst_line;
         rst_s2_ff <= rst_s1_ff;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n || rst_s2_ff) begin
         rstc_ff <= '0;
         pin_rst_ff <= 1'b0;
      end else if (rstc_ff == RSTC_W'(RST_PULSE_CYC)) begin
         pin_rst_ff <= 1'b1;
      end else begin
         rstc_ff <= rstc_ff + 1'b1;
      end
   end

   assign srst_n = reset_n & ~pin_rst_ff;
   assign fall = rxd_d_ff & ~rxd_s2_ff;
   assign bit_last = CNT_W'(bit_per_ff) - 1'b1;
   assign lock_evt = (st_ff == S_SYNC_STOP) && rxd_s2_ff;

   // Sync byte measurement and receiver
   always_ff @(posedge clk) begin
      if (!srst_n) begin
         st_ff <= S_WAIT_IDLE;
         cnt_ff <= '0;
         bit_per_ff <= '0;
         nb_ff <= '0;
         rsh_ff <= '0;
         cmd_data_ff <= '0;
         cmd_valid_ff <= 1'b0;
      end else begin
         cmd_valid_ff <= 1'b0;
         unique case (st_ff)
            S_WAIT_IDLE: begin
               if (rxd_s2_ff) begin
                  st_ff <= S_WAIT_SYNC;
               end
            end
            S_WAIT_SYNC: begin
               if (fall) begin
                  cnt_ff <= '0;
                  nb_ff <= '0;
                  st_ff <= S_MEASURE;
               end
            end
            S_MEASURE: begin
               cnt_ff <= cnt_ff + 1'b1;
               if (cnt_ff == MEAS_LIMIT) begin
                  st_ff <= S_WAIT_IDLE;
               end else if (fall) begin
                  if (nb_ff == SYNC_FALLS - 1'b1) begin
                     // Five falls span eight bits of 55h
                     bit_per_ff <= BIT_W'((cnt_ff + 1'b1) >> 3);
                     st_ff <= S_SYNC_STOP;
                  end else begin
                     nb_ff <= nb_ff + 1'b1;
                  end
               end
            end
            S_SYNC_STOP: begin
               if (rxd_s2_ff) begin
                  st_ff <= S_IDLE;
               end
            end
            S_IDLE: begin
               if (fall) begin
                  cnt_ff <= '0;
                  st_ff <= S_START;
               end
            end
            S_START: begin
               cnt_ff <= cnt_ff + 1'b1;
               if (cnt_ff == CNT_W'(bit_per_ff >> 1)) begin
                  cnt_ff <= '0;
                  nb_ff <= '0;
                  st_ff <= rxd_s2_ff ? S_IDLE : S_DATA;
               end
            end
            S_DATA: begin
               cnt_ff <= cnt_ff + 1'b1;
               if (cnt_ff == bit_last) begin
                  cnt_ff <= '0;
                  rsh_ff <= {rxd_s2_ff, rsh_ff[7:1]};
                  nb_ff <= nb_ff + 1'b1;
                  if (nb_ff == LAST_BIT) begin
                     st_ff <= S_STOP;
                  end
               end
            end
            S_STOP: begin
               cnt_ff <= cnt_ff + 1'b1;
               if (cnt_ff == bit_last) begin
                  st_ff <= S_IDLE;
                  if (rxd_s2_ff && ready_ff) begin
                     cmd_data_ff <= rsh_ff;
                     cmd_valid_ff <= 1'b1;
                  end
               end
            end
         endcase
      end
   end

   // Lock and readiness
   always_ff @(posedge clk) begin
      if (!srst_n) begin
         locked_ff <= 1'b0;
         ab_pend_ff <= 1'b0;
         ready_ff <= 1'b0;
      end else begin
         if (lock_evt) begin
            locked_ff <= 1'b1;
            ab_pend_ff <= 1'b1;
         end else if (ab_pend_ff && fin_ready) begin
            ab_pend_ff <= 1'b0;
         end
         if (locked_ff && !ab_pend_ff && !fout_valid && !tbusy_ff) begin
            ready_ff <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!srst_n) begin
         spl_ff <= '0;
         splash_ff <= 1'b0;
      end else if (!locked_ff && !splash_ff) begin
         spl_ff <= spl_ff + 1'b1;
         if (spl_ff == SPW'(SPLASH_CYCLES - 1)) begin
            splash_ff <= 1'b1;
         end
      end
   end

   // Response byte selection
   always_comb begin
      if (ab_pend_ff) begin
         fin_data = ACK_BYTE;
      end else if (done_req) begin
         fin_data = done_ok ? ACK_BYTE : NAK_BYTE;
      end else begin
         fin_data = rsp_data;
      end
   end

   assign fin_valid = ab_pend_ff | (ready_ff & (done_req | rsp_valid));
   assign done_ready = fin_ready & ~ab_pend_ff & ready_ff;
   assign rsp_ready = done_ready & ~done_req;
   assign fout_ready = locked_ff & ~tbusy_ff;

   sclab_fifo2 #(.W(8), .DEPTH(2)) u_txbuf (
      .clk(clk),
      .reset_n(srst_n),
      .in_data(fin_data),
      .in_valid(fin_valid),
      .in_ready(fin_ready),
      .out_data(fout_data),
      .out_valid(fout_valid),
      .out_ready(fout_ready)
   );

   assign bit_end = tcnt_ff == bit_per_ff - 1'b1;

   // Transmitter
   always_ff @(posedge clk) begin
      if (!srst_n) begin
         txd_ff <= 1'b1;
         tbusy_ff <= 1'b0;
         tsh_ff <= '1;
         tbit_ff <= '0;
         tcnt_ff <= '0;
      end else if (!tbusy_ff) begin
         if (fout_valid && fout_ready) begin
            txd_ff <= 1'b0;
            tsh_ff <= {1'b1, fout_data};
            tbit_ff <= '0;
            tcnt_ff <= '0;
            tbusy_ff <= 1'b1;
         end
      end else if (bit_end) begin
         tcnt_ff <= '0;
         if (tbit_ff == STOP_IDX) begin
            tbusy_ff <= 1'b0;
         end else begin
            txd_ff <= tsh_ff[0];
            tsh_ff <= {1'b1, tsh_ff[8:1]};
            tbit_ff <= tbit_ff + 1'b1;
         end
      end else begin
         tcnt_ff <= tcnt_ff + 1'b1;
      end
   end

   assign link.dev_txd = txd_ff;
   assign cmd_data = cmd_data_ff;
   assign cmd_valid = cmd_valid_ff;
   assign baud_locked = locked_ff;
   assign link_ready = ready_ff;
   assign splash_on = splash_ff;
   assign bit_cycles = bit_per_ff;
endmodule

// [src/sclab_pkg.sv]
package sclab_pkg;
   localparam int CLK_HZ = 20_000_000;
   localparam int CLK_MHZ = CLK_HZ / 1_000_000;
   localparam int MS_CYC = CLK_HZ / 1000;
   // Reset pulse must be longer than this
   localparam int RST_PULSE_NS = 2000;
   localparam int RST_PULSE_CYC = RST_PULSE_NS * CLK_MHZ / 1000 + 1;
   localparam int SPLASH_S = 5;
   localparam int SPLASH_CYC = SPLASH_S * CLK_HZ;
   localparam int SPW = 27;
   localparam int SETTLE_MS = 500;
   localparam int CARD_INIT_MS = 1000;
   localparam int SETTLE_CYC = (SETTLE_MS + CARD_INIT_MS) * MS_CYC;
   localparam int HSW = 25;
   localparam int BAUD_MIN = 300;
   localparam int BAUD_MAX = 256_000;
   localparam int BIT_CYC_MAX = CLK_HZ / BAUD_MIN;
   localparam int BIT_CYC_MIN = CLK_HZ / BAUD_MAX;
   localparam int CNT_W = 20;
   localparam int BIT_W = 17;
   localparam logic [CNT_W-1:0] MEAS_LIMIT = CNT_W'(9 * BIT_CYC_MAX);
   localparam logic [2:0] SYNC_FALLS = 3'h4;
   localparam logic [3:0] STOP_IDX = 4'h9;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam int HOST_BAUD = 115_200;
   localparam int HOST_DIV = CLK_HZ / HOST_BAUD;
   localparam logic [7:0] ACK_BYTE = 8'h06;
   localparam logic [7:0] NAK_BYTE = 8'h15;
   localparam logic [7:0] SYNC_BYTE = 8'h55;
   localparam int RSTC_W = 6;
   typedef enum logic [2:0] {
      S_WAIT_IDLE, S_WAIT_SYNC, S_MEASURE, S_SYNC_STOP, S_IDLE, S_START, S_DATA, S_STOP
   } sclab_rx_e;
   typedef enum logic [2:0] {H_RESET, H_SETTLE, H_SYNC, H_WAIT_ACK, H_UP} sclab_host_e;
endpackage

// [src/sclab_link_if.sv]
`timescale 1ns/10ps
interface sclab_link_if;
   logic host_txd;
   logic dev_txd;
   logic rst_o;
   logic rst_oe_n;
   logic rst_line;
   // Open-drain reset with pull-up
   assign rst_line = rst_oe_n ? 1'b1 : rst_o;
   modport dev (input host_txd, input rst_line, output dev_txd);
   modport host (output host_txd, output rst_o, output rst_oe_n, input dev_txd, input rst_line);
endinterface

// [src/sclab_fifo2.sv]
`timescale 1ns/10ps
module sclab_fifo2 #(
   parameter int W = 8,
   parameter int DEPTH = 2
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [W-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [W-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;
   logic [W-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wr_ff;
   logic [AW-1:0] rd_ff;
   logic [CW-1:0] cnt_ff;
   logic push;
   logic pop;

   assign in_ready = cnt_ff != CW'(DEPTH);
   assign out_valid = cnt_ff != '0;
   assign out_data = mem_ff[rd_ff];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_ff[wr_ff] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) begin
            wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
         end
         if (pop) begin
            rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
         end
         cnt_ff <= cnt_ff + CW'(push) - CW'(pop);
      end
   end
endmodule

// [src/sclab_host.sv]
`timescale 1ns/10ps
module sclab_host import sclab_pkg::*; #(
   parameter int SETTLE_CYCLES = SETTLE_CYC,
   parameter int BAUD_DIV = HOST_DIV
) (
   input wire logic clk,
   input wire logic reset_n,
   sclab_link_if.host link,
   input wire logic reset_req,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   output logic [7:0] rx_data,
   output logic rx_valid,
   output logic link_up
);
   sclab_host_e st_ff;
   logic [HSW-1:0] wcnt_ff;
   logic rst_oe_n_ff;
   logic rxd_s1_ff;
   logic rxd_s2_ff;
   logic [BIT_W-1:0] rcnt_ff;
   logic [3:0] rbit_ff;
   logic rbusy_ff;
   logic [7:0] rsh_ff;
   logic [7:0] rx_data_ff;
   logic rx_valid_ff;
   logic txd_ff;
   logic tbusy_ff;
   logic [8:0] tsh_ff;
   logic [3:0] tbit_ff;
   logic [BIT_W-1:0] tcnt_ff;
   logic rx_en;
   logic send;
   logic [7:0] send_data;

   assign rx_en = (st_ff == H_WAIT_ACK) || (st_ff == H_UP);
   assign tx_ready = (st_ff == H_UP) && !tbusy_ff;
   assign send = ((st_ff == H_SYNC) && !tbusy_ff) || (tx_valid && tx_ready);
   assign send_data = (st_ff == H_SYNC) ? SYNC_BYTE : tx_data;

   // Bring-up sequence
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_ff <= H_SETTLE;
         wcnt_ff <= '0;
         rst_oe_n_ff <= 1'b1;
      end else if (reset_req) begin
         st_ff <= H_RESET;
         wcnt_ff <= '0;
      end else begin
         unique case (st_ff)
            H_RESET: begin
               rst_oe_n_ff <= 1'b0;
               wcnt_ff <= wcnt_ff + 1'b1;
               if (wcnt_ff == HSW'(RST_PULSE_CYC + 2)) begin
                  rst_oe_n_ff <= 1'b1;
                  wcnt_ff <= '0;
                  st_ff <= H_SETTLE;
               end
            end
            H_SETTLE: begin
               wcnt_ff <= wcnt_ff + 1'b1;
               if (wcnt_ff == HSW'(SETTLE_CYCLES - 1)) begin
                  st_ff <= H_SYNC;
               end
            end
            H_SYNC: begin
               if (send) begin
                  st_ff <= H_WAIT_ACK;
               end
            end
            H_WAIT_ACK: begin
               if (rx_valid_ff && rx_data_ff == ACK_BYTE) begin
                  st_ff <= H_UP;
               end
            end
            H_UP: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rxd_s1_ff <= 1'b1;
         rxd_s2_ff <= 1'b1;
      end else begin
         rxd_s1_ff <= link.dev_txd;
         rxd_s2_ff <= rxd_s1_ff;
      end
   end

   // Receiver, centre sampled
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rbusy_ff <= 1'b0;
         rcnt_ff <= '0;
         rbit_ff <= '0;
         rsh_ff <= '0;
         rx_data_ff <= '0;
         rx_valid_ff <= 1'b0;
      end else begin
         rx_valid_ff <= 1'b0;
         if (!rbusy_ff) begin
            if (rx_en && !rxd_s2_ff) begin
               rbusy_ff <= 1'b1;
               rcnt_ff <= BIT_W'(BAUD_DIV / 2);
               rbit_ff <= '0;
            end
         end else if (rcnt_ff == BIT_W'(BAUD_DIV - 1)) begin
            rcnt_ff <= '0;
            rbit_ff <= rbit_ff + 1'b1;
            if (rbit_ff == 4'h0 && rxd_s2_ff) begin
               rbusy_ff <= 1'b0;
            end else if (rbit_ff == STOP_IDX) begin
               rbusy_ff <= 1'b0;
               if (rxd_s2_ff) begin
                  rx_data_ff <= rsh_ff;
                  rx_valid_ff <= 1'b1;
               end
            end else if (rbit_ff != 4'h0) begin
               rsh_ff <= {rxd_s2_ff, rsh_ff[7:1]};
            end
         end else begin
            rcnt_ff <= rcnt_ff + 1'b1;
         end
      end
   end

   // Transmitter, idles high from reset
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         txd_ff <= 1'b1;
         tbusy_ff <= 1'b0;
         tsh_ff <= '1;
         tbit_ff <= '0;
         tcnt_ff <= '0;
      end else if (!tbusy_ff) begin
         if (send) begin
            txd_ff <= 1'b0;
            tsh_ff <= {1'b1, send_data};
            tbit_ff <= '0;
            tcnt_ff <= '0;
            tbusy_ff <= 1'b1;
         end
      end else if (tcnt_ff == BIT_W'(BAUD_DIV - 1)) begin
         tcnt_ff <= '0;
         if (tbit_ff == STOP_IDX) begin
            tbusy_ff <= 1'b0;
         end else begin
            txd_ff <= tsh_ff[0];
            tsh_ff <= {1'b1, tsh_ff[8:1]};
            tbit_ff <= tbit_ff + 1'b1;
         end
      end else begin
         tcnt_ff <= tcnt_ff + 1'b1;
      end
   end

   assign link.host_txd = txd_ff;
   assign link.rst_o = 1'b0;
   assign link.rst_oe_n = rst_oe_n_ff;
   assign rx_data = rx_data_ff;
   assign rx_valid = rx_valid_ff & (st_ff == H_UP);
   assign link_up = st_ff == H_UP;
endmodule

// [tb/sclab_link_checker.sv]
`timescale 1ns/10ps
module sclab_link_checker import sclab_pkg::*; #(
   parameter int BIT = HOST_DIV
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic host_txd,
   input wire logic dev_txd,
   input wire logic rst_oe_n,
   input wire logic rst_line
);
   logic [15:0] dlow_ff;
   logic [15:0] hlow_ff;
   logic [15:0] rlow_ff;
   logic heard_ff;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // Low run lengths of each line
   always_ff @(posedge clk) begin
      dlow_ff <= (!reset_n || dev_txd) ? 16'h0000 : dlow_ff + 16'h0001;
      hlow_ff <= (!reset_n || host_txd) ? 16'h0000 : hlow_ff + 16'h0001;
      rlow_ff <= (!reset_n || rst_oe_n) ? 16'h0000 : rlow_ff + 16'h0001;
   end

   // Host has started a frame since the last reset
   always_ff @(posedge clk) begin
      if (!reset_n || !rst_line) begin
         heard_ff <= 1'b0;
      end else if (!host_txd) begin
         heard_ff <= 1'b1;
      end
   end

   dev_bit_len_a: assert property ($rose(dev_txd) |-> (dlow_ff % BIT) == 0)
      else $error("device low run not whole bits");
   host_bit_len_a: assert property ($rose(host_txd) |-> (hlow_ff % BIT) == 0)
      else $error("host low run not whole bits");
   dev_stop_high_a: assert property (dlow_ff <= 16'(9 * BIT))
      else $error("device line low past stop bit");
   host_stop_high_a: assert property (hlow_ff <= 16'(9 * BIT))
      else $error("host line low past stop bit");
   reset_pulse_len_a: assert property ($rose(rst_oe_n) |-> rlow_ff >= 16'(RST_PULSE_CYC))
      else $error("reset pulse too short");
   idle_after_reset_a: assert property ($rose(reset_n) |-> host_txd && dev_txd)
      else $error("lines not idle high after reset");
   no_early_tx_a: assert property (!dev_txd |-> heard_ff)
      else $error("device sent before any host frame");
   pin_reset_quiet_a: assert property ($rose(rst_line) |-> dev_txd && host_txd)
      else $error("line active across pin reset");

   cover property ($fell(dev_txd));
   cover property ($rose(rst_oe_n));
   cover property ($rose(host_txd) && hlow_ff == 16'(9 * BIT));
endmodule

// [tb/tb_top.sv]
`timescale 1ns/10ps
module tb_top import sclab_pkg::*;;
   localparam int DIV = 40;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic reset_req, tx_valid, tx_ready, rx_valid, link_up;
   logic [7:0] tx_data, rx_data, cmd_data, rsp_data;
   logic cmd_valid, rsp_valid, rsp_ready, done_req, done_ok, done_ready;
   logic baud_locked, link_ready, splash_on, lock2, splash2;
   logic [BIT_W-1:0] bit_cycles;
   logic rx_on = 1'b0;
   logic d2_tx = 1'b0;
   logic [31:0] seed = 32'h0453;
   logic [7:0] cmd_q[$];
   logic [7:0] rx_q[$];
   int miscompares = 0;
   int n_compared = 0;
   int cycles = 0;

   sclab_link_if lk();
   sclab_link_if lk2();

   sclab_host #(.SETTLE_CYCLES(100), .BAUD_DIV(DIV)) sclab_host_i (.clk(clk), .reset_n(reset_n), .link(lk),
      .reset_req(reset_req), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
      .rx_valid(rx_valid), .link_up(link_up));
   sclab_device #(.SPLASH_CYCLES(2000)) sclab_device_i (.clk(clk), .reset_n(reset_n), .link(lk),
      .cmd_data(cmd_data), .cmd_valid(cmd_valid), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
      .rsp_ready(rsp_ready), .done_req(done_req), .done_ok(done_ok), .done_ready(done_ready),
      .baud_locked(baud_locked), .link_ready(link_ready), .splash_on(splash_on), .bit_cycles(bit_cycles));
   // Second device whose receive line is stuck low from power-up
   sclab_device #(.SPLASH_CYCLES(2000)) sclab_device_i2 (.clk(clk), .reset_n(reset_n), .link(lk2),
      .cmd_data(), .cmd_valid(), .rsp_data(rsp_data), .rsp_valid(1'b0), .rsp_ready(), .done_req(1'b0),
      .done_ok(done_ok), .done_ready(), .baud_locked(lock2), .link_ready(), .splash_on(splash2), .bit_cycles());
   assign lk2.host_txd = 1'b0;
   assign lk2.rst_o = 1'b0;
   assign lk2.rst_oe_n = 1'b1;

   sclab_link_checker #(.BIT(DIV)) sclab_link_checker_i (.clk(clk), .reset_n(reset_n),
      .host_txd(lk.host_txd), .dev_txd(lk.dev_txd), .rst_oe_n(lk.rst_oe_n), .rst_line(lk.rst_line));

   initial begin
      forever #25 clk = ~clk;
   end

   function logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction

   task automatic tick();
      @(posedge clk);
      #2;
   endtask

   task chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task chkv(input string nm, input logic [BIT_W-1:0] e, input logic [BIT_W-1:0] g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task tally_and_finish();
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic hsend(input logic [7:0] d);
      tx_data = d;
      tx_valid = 1'b1;
      cmd_q.push_back(d);
      #1;
      while (tx_ready !== 1'b1) tick();
      tick();
   endtask

   // Plain answer when dn is set (d[0] picks success), else a reply byte
   task automatic dput(input logic dn, input logic [7:0] d);
      done_req = dn;
      rsp_valid = !dn;
      done_ok = d[0];
      rsp_data = d;
      rx_q.push_back(dn ? (d[0] ? ACK_BYTE : NAK_BYTE) : d);
      #1;
      while ((dn ? done_ready : rsp_ready) !== 1'b1) tick();
      tick();
   endtask

   task sync_up();
      while (baud_locked !== 1'b1 || link_up !== 1'b1) tick();
      repeat (DIV) tick();
      chkv("link_ready", BIT_W'(1), BIT_W'(link_ready));
      chkv("bit_cycles", BIT_W'(DIV), bit_cycles);
      chkv("line_idle", BIT_W'(3), BIT_W'({lk.host_txd, lk.dev_txd}));
      rx_on = 1'b1;
   endtask

   task drain();
      tx_valid = 1'b0;
      rsp_valid = 1'b0;
      done_req = 1'b0;
      while (cmd_q.size() + rx_q.size() > 0) tick();
      repeat (DIV) tick();
   endtask

   always @(negedge clk) begin
      if (cmd_valid === 1'b1) begin
         chk8("cmd_data", cmd_q.size() > 0 ? cmd_q.pop_front() : 8'hXX, cmd_data);
      end
      if (rx_on && rx_valid === 1'b1) begin
         chk8("rx_data", rx_q.size() > 0 ? rx_q.pop_front() : 8'hXX, rx_data);
      end
      if (reset_n && lk2.dev_txd !== 1'b1) begin
         d2_tx = 1'b1;
      end
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         miscompares++;
         $display("Error run_length expected done seen hang");
         tally_and_finish();
      end
   end

   initial begin
      reset_req = 1'b0;
      tx_data = 8'h00;
      tx_valid = 1'b0;
      rsp_data = 8'h00;
      rsp_valid = 1'b0;
      done_req = 1'b0;
      done_ok = 1'b0;
      repeat (12) @(posedge clk);
      #2;
      reset_n = 1'b1;
      sync_up();
      $display("test sync done");
      for (int i = 0; i < 8; i++) begin
         hsend(i == 0 ? 8'h00 : (i == 1 ? 8'hFF : rnd()));
      end
      drain();
      $display("test host to device done");
      // Both directions at once; reply burst fills the buffer and dput waits on ready
      fork
         for (int i = 0; i < 4; i++) begin
            hsend(rnd());
         end
         begin
            dput(1'b1, 8'h01);
            dput(1'b1, 8'h00);
            for (int i = 0; i < 4; i++) begin
               dput(1'b0, rnd());
            end
         end
      join
      drain();
      $display("test full duplex done");
      rx_on = 1'b0;
      reset_req = 1'b1;
      tick();
      reset_req = 1'b0;
      repeat (60) tick();
      chkv("baud_locked", BIT_W'(0), BIT_W'(baud_locked));
      sync_up();
      hsend(rnd());
      dput(1'b0, rnd());
      drain();
      $display("test pin reset done");
      chkv("splash_on", BIT_W'(0), BIT_W'(splash_on));
      chkv("stuck_splash", BIT_W'(1), BIT_W'(splash2));
      chkv("stuck_lock", BIT_W'(0), BIT_W'(lock2));
      chkv("stuck_tx", BIT_W'(0), BIT_W'(d2_tx));
      $display("test stuck line done");
      tally_and_finish();
   end
endmodule
